// ===== logic/tqe_pkg.sv
`default_nettype none
package tqe_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam int unsigned IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_MQ_HI_TOP = 10'h158;
    localparam logic [IDX_W-1:0] IDX_MQ_HI_LOW = 10'h15a;
    localparam logic [IDX_W-1:0] IDX_MQ_UPPER = 10'h15c;
    localparam logic [IDX_W-1:0] IDX_MQ_LOWER = 10'h15e;
    localparam logic [IDX_W-1:0] IDX_SQ_UPPER = 10'h16c;
    localparam logic [IDX_W-1:0] IDX_SQ_LOWER = 10'h16e;
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h170;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned MASK_W = 16;
    localparam logic [MASK_W-1:0] MASK_RESET = 16'h0000;
    localparam int unsigned CTRL_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam int unsigned CTRL_DEV_SEL_BIT = 0;
    localparam int unsigned CTRL_SHARED_BIT = 1;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned MQ_QUEUES = 64;
    localparam int unsigned SHARED_QUEUES = 32;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : tqe_pkg
`default_nettype wire

// ===== logic/tqe_regs.sv
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
module tqe_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Queue enables to the transmit logic
    output logic [tqe_pkg::MQ_QUEUES-1:0] queue_en_o,
    output logic [tqe_pkg::SHARED_QUEUES-1:0] shared_queue_en_o,
    output logic [tqe_pkg::SHARED_QUEUES-1:0] slave_queue_en_o,
    output logic shared_mode_o
);
    import tqe_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [MASK_W-1:0] mq_hi_top;
        logic [MASK_W-1:0] mq_hi_low;
        logic [MASK_W-1:0] mq_upper;
        logic [MASK_W-1:0] mq_lower;
        logic [MASK_W-1:0] sq_upper;
        logic [MASK_W-1:0] sq_lower;
        logic [CTRL_W-1:0] ctrl;
        logic [MQ_QUEUES-1:0] q_en;
        logic [SHARED_QUEUES-1:0] sh_en;
        logic [SHARED_QUEUES-1:0] sl_en;
        logic shared;
    } tqe_state_s;

    tqe_state_s st;
    tqe_state_s next_st;

    logic [IDX_W-1:0] idx;
    logic req;
    logic dev_sel;
    logic shared;

    assign idx = adr_i[IDX_W+1:2];
    assign req = cyc_i & stb_i & ~st.ack;
    assign dev_sel = st.ctrl[CTRL_DEV_SEL_BIT];
    assign shared = st.ctrl[CTRL_SHARED_BIT];

    // Byte-lane merge of a 16-bit mask
    function automatic logic [MASK_W-1:0] merge16(input logic [MASK_W-1:0] old,
                                                  input logic [31:0] wd,
                                                  input logic [3:0] sel);
        logic [MASK_W-1:0] r;
        r = old;
        if (sel[0]) begin
            r[BYTE_W-1:0] = wd[BYTE_W-1:0];
        end
        if (sel[1]) begin
            r[MASK_W-1:BYTE_W] = wd[MASK_W-1:BYTE_W];
        end
        return r;
    endfunction : merge16

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = req;
        if (req) begin
            next_st.dat = DATA_ZERO;
            if (we_i) begin
                if (idx == IDX_MQ_HI_TOP) begin
                    next_st.mq_hi_top = merge16(st.mq_hi_top, dat_i, sel_i);
                end else if (idx == IDX_MQ_HI_LOW) begin
                    next_st.mq_hi_low = merge16(st.mq_hi_low, dat_i, sel_i);
                end else if (idx == IDX_MQ_UPPER) begin
                    next_st.mq_upper = merge16(st.mq_upper, dat_i, sel_i);
                end else if (idx == IDX_MQ_LOWER) begin
                    next_st.mq_lower = merge16(st.mq_lower, dat_i, sel_i);
                end else if (idx == IDX_SQ_UPPER) begin
                    next_st.sq_upper = merge16(st.sq_upper, dat_i, sel_i);
                end else if (idx == IDX_SQ_LOWER) begin
                    next_st.sq_lower = merge16(st.sq_lower, dat_i, sel_i);
                end else if (idx == IDX_CTRL) begin
                    if (sel_i[0]) begin
                        next_st.ctrl = dat_i[CTRL_W-1:0];
                    end
                end
            end else begin
                // Unmapped reads return zero; upper bits always zero
                if (idx == IDX_MQ_HI_TOP) begin
                    next_st.dat[MASK_W-1:0] = st.mq_hi_top;
                end else if (idx == IDX_MQ_HI_LOW) begin
                    next_st.dat[MASK_W-1:0] = st.mq_hi_low;
                end else if (idx == IDX_MQ_UPPER) begin
                    next_st.dat[MASK_W-1:0] = st.mq_upper;
                end else if (idx == IDX_MQ_LOWER) begin
                    next_st.dat[MASK_W-1:0] = st.mq_lower;
                end else if (idx == IDX_SQ_UPPER) begin
                    next_st.dat[MASK_W-1:0] = st.sq_upper;
                end else if (idx == IDX_SQ_LOWER) begin
                    next_st.dat[MASK_W-1:0] = st.sq_lower;
                end else if (idx == IDX_CTRL) begin
                    next_st.dat[CTRL_W-1:0] = st.ctrl;
                end
            end
        end

        // Effective enables; a one bit enables its queue
        next_st.q_en[15:0] = st.mq_lower;
        next_st.q_en[31:16] = st.mq_upper;
        // Upper half forced off while the device is not selected
        next_st.q_en[47:32] = dev_sel ? st.mq_hi_low : MASK_RESET;
        next_st.q_en[63:48] = dev_sel ? st.mq_hi_top : MASK_RESET;
        // Sharing only ever sees the low 32 queues
        next_st.sh_en = shared ? {st.mq_upper, st.mq_lower} : DATA_ZERO;
        // Slave view is dead outside shared mode
        next_st.sl_en = shared ? {st.sq_upper, st.sq_lower} : DATA_ZERO;
        next_st.shared = shared;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dat_o = st.dat;
    assign ack_o = st.ack;
    assign queue_en_o = st.q_en;
    assign shared_queue_en_o = st.sh_en;
    assign slave_queue_en_o = st.sl_en;
    assign shared_mode_o = st.shared;
endmodule : tqe_regs
`default_nettype wire

// ===== dv/tqe_regs_checker.sv
`default_nettype none
module tqe_regs_checker import tqe_pkg::*; (
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, shared_mode_o,
    input wire logic [31:0] adr_i, dat_i, dat_o, shared_queue_en_o, slave_queue_en_o,
    input wire logic [3:0] sel_i,
    input wire logic [63:0] queue_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rq, wr;
    assign rq = cyc_i && stb_i && !ack_o;
    assign wr = rq && we_i && sel_i[1:0] == 2'h3;
    property p_ack; rq |=> ack_o && dat_o[31:16] == 16'h0; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_one; ack_o |=> !ack_o; endproperty
    a_one: assert property (p_one) else $error("one");
    property p_lo; wr && adr_i[11:2] == IDX_MQ_LOWER |-> ##2 queue_en_o[15:0] == $past(dat_i[15:0], 2); endproperty
    a_lo: assert property (p_lo) else $error("lo");
    property p_up; wr && adr_i[11:2] == IDX_MQ_UPPER |-> ##2 queue_en_o[31:16] == $past(dat_i[15:0], 2); endproperty
    a_up: assert property (p_up) else $error("up");
    property p_off; wr && adr_i[11:2] == IDX_CTRL && !dat_i[0] |-> ##2 queue_en_o[63:32] == 32'h0; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_sh; shared_mode_o |-> shared_queue_en_o == queue_en_o[31:0]; endproperty
    a_sh: assert property (p_sh) else $error("sh");
    property p_sq; wr && adr_i[11:2] == IDX_SQ_UPPER |->
        ##2 slave_queue_en_o[31:16] == ($past(dat_i[15:0], 2) & {16{shared_mode_o}}); endproperty
    a_sq: assert property (p_sq) else $error("sq");
    property p_idle; !shared_mode_o |-> (slave_queue_en_o | shared_queue_en_o) == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("idle");
endmodule : tqe_regs_checker
bind tqe_regs tqe_regs_checker u_tqe_regs_checker (.*);
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns / 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, shared_mode_o;
    logic [3:0] sel_i = 0;
    logic [31:0] adr_i = 0, dat_i = 0, dat_o, shared_queue_en_o, slave_queue_en_o;
    logic [63:0] queue_en_o;
    logic [11:0] ad[8] = '{12'h560, 12'h568, 12'h570, 12'h578, 12'h5b0, 12'h5b8, 12'h5c0, 12'h5c4};
    logic [15:0] m[8] = '{default: 16'h0};
    int fail_count = 0, total_checks = 0, cy = 0, k;
    tqe_regs u_tqe_regs (.*);
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cy == 3000) begin
        fail_count++;
        report_and_stop();
    end
    task automatic chk(string n, logic [128:0] s, e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic wb(logic w, int i, logic [31:0] d, logic [3:0] s);
        logic [128:0] e;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= {20'h0, ad[i]};
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 0;
        stb_i <= 0;
        if (!w) chk("rd", dat_o, {16'h0, m[i]});
        else if (i == 6 && s[0]) m[6] = {14'h0, d[1:0]};
        else if (i < 6) m[i] = {s[1] ? d[15:8] : m[i][15:8], s[0] ? d[7:0] : m[i][7:0]};
        // Enables lag a cycle
        @(negedge clk_i);
        e = {m[6][0] ? {m[0], m[1]} : 32'h0, m[2], m[3], m[6][1] ? {m[2], m[3], m[4], m[5], 1'b1} : 65'h0};
        chk("en", {queue_en_o, shared_queue_en_o, slave_queue_en_o, shared_mode_o}, e);
    endtask : wb
    initial begin
        k = $urandom(99);
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        for (k = 0; k < 8; k++) wb(0, k, 0, 0);
        $display("reset done");
        repeat (80) wb(1'($urandom), $urandom_range(7), $urandom, 4'($urandom));
        $display("random done");
        for (k = 0; k < 32; k++) wb(1, k % 8, k % 8 == 6 ? k / 8 : $urandom, 4'hf);
        $display("mode done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
